// ==== hdl/adc_cfg_pkg.sv ====
// Package for the converter configuration and test register bank.
// Assumes one clock and pre-decoded byte register accesses.
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_PORT_CONFIG = 13'h0000;
  localparam logic [12:0] ADDR_CORE_SELECT = 13'h0010;
  localparam logic [12:0] ADDR_POWER_DOWN = 13'h0025;
  localparam logic [12:0] ADDR_SKEW_TRIM = 13'h0070;
  localparam logic [12:0] ADDR_CLOCK_ADVANCE = 13'h0071;
  localparam logic [12:0] ADDR_DIVIDER = 13'h0072;
  localparam logic [12:0] ADDR_STYLE_PRIMARY = 13'h0073;
  localparam logic [12:0] ADDR_STYLE_SECONDARY = 13'h0074;
  localparam logic [12:0] ADDR_LOOP_STATE = 13'h0075;
  localparam logic [12:0] ADDR_TEST_CONTROL = 13'h00C0;
  localparam logic [12:0] ADDR_WORD_ONE_LOW = 13'h00C2;
  localparam logic [12:0] ADDR_WORD_ONE_HIGH = 13'h00C3;
  localparam logic [12:0] ADDR_WORD_TWO_LOW = 13'h00C4;
  localparam logic [12:0] ADDR_WORD_TWO_HIGH = 13'h00C5;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 5;
  localparam int LOOP_RANGE_BIT = 6;
  localparam int DDR_ENABLE_BIT = 4;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_SKEW = 8'h80;
  localparam logic [7:0] NO_CORE_CODE = 8'hAD;
  localparam logic [1:0] CORE_ZERO = 2'h1;
  localparam logic [1:0] CORE_ONE = 2'h2;
  localparam int TEST_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Override codes shared by the three-bit select fields
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_PIN = 3'h0;
  localparam logic [2:0] CODE_ONE = 3'h1;
  localparam logic [2:0] CODE_TWO = 3'h2;
  localparam logic [2:0] CODE_FOUR = 3'h4;

  // ----------------------------------------------------------------
  // Test pattern codes and fixed words
  // ----------------------------------------------------------------
  localparam logic [3:0] PAT_OFF = 4'h0;
  localparam logic [3:0] PAT_MID = 4'h1;
  localparam logic [3:0] PAT_ONES = 4'h2;
  localparam logic [3:0] PAT_ZEROS = 4'h3;
  localparam logic [3:0] PAT_CHECKER = 4'h4;
  localparam logic [3:0] PAT_ONE_ZERO = 4'h7;
  localparam logic [3:0] PAT_USER = 4'h8;
  localparam logic [1:0] TEST_STATIC = 2'h0;
  localparam logic [1:0] TEST_ALTERNATE = 2'h1;
  localparam logic [15:0] WORD_MID = 16'h8000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_CHECK_A = 16'hAAAA;
  localparam logic [15:0] WORD_CHECK_B = 16'h5555;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POWER_NORMAL = 2'b00,
    POWER_NAP = 2'b01,
    POWER_SLEEP = 2'b10
  } power_state_t;

  typedef enum logic [1:0] {
    DRIVE_DIFF_2MA = 2'b00,
    DRIVE_DIFF_3MA = 2'b01,
    DRIVE_CMOS = 2'b10
  } drive_style_t;

  typedef enum logic [1:0] {
    CODING_TWOS = 2'b00,
    CODING_GRAY = 2'b01,
    CODING_OFFSET = 2'b10
  } coding_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] pattern;
    logic [1:0] mode;
    logic [15:0] word_one;
    logic [15:0] word_two;
  } test_cfg_t;

endpackage : adc_cfg_pkg

// ==== hdl/adc_config_test_register_bank.sv ====
// Configuration and test register bank of a dual-core interleaved converter.
// Assumes pre-decoded byte register accesses from the serial port.
//
// Summary of operation
// - Power-down field: 000 pin, 001 normal, 010 nap, 100 sleep.
// - Soft reset leaves power-down, divider and primary output style registers alone.
// - Register power-down hits only the selected core; pin setting hits both cores.
// - Eight-bit skew trim, resets to 0x80, 0x00 minimum delay, 0xFF maximum.
// - In divide-by-two, an advance forces the divided clock high, so its edges slip one input cycle only if it was already high.
// - Divider field: 000 pin, 001 divide by one, 010 divide by two; 100 forbidden.
// - Output style bits 7:5: pin, 2mA differential, 3mA differential, single-ended CMOS.
// - Coding bits 2:0: pin, two's complement, Gray code, offset binary.
// - Loop-range bit 6 selects fast by default, or slow.
// - DDR and loop range follow the loop-state register alone, which each secondary style write updates.
// - Test output drives one fixed word, or two words on alternating phases.
// - Test enable is recognised late, so the pattern appears after several cycles.
// - Test mode bits 7:6: 0 static, 1 alternate, other codes reserved.
// - Pattern nibble selects off, midscale, ones, zeros, checkerboard, one/zero, user words.
// - Each user word is built from a low-byte and a high-byte register.
// - Indexed accesses hit only the core chosen at 0x10; none after reset.
// - Soft-reset bit returns every non-exempt register to its default.
`timescale 1ns/1ps
module adc_config_test_register_bank
  import adc_cfg_pkg::*;
#(
  parameter int WORD_WIDTH = 16,
  parameter int CORES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register access from the serial port
  input adc_cfg_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Tri-level pin settings, resolved to codes
  input wire logic [1:0] power_state_select_pin,
  input wire logic divisor_select_pin,
  input wire logic [1:0] output_style_select_pin,
  input wire logic [1:0] coding_select_pin,
  // Core controls
  output adc_cfg_pkg::power_state_t core_power [CORES],
  output logic [7:0] core_skew_trim,
  output logic divide_by_two,
  output logic divided_clock,
  // Output controls
  output adc_cfg_pkg::drive_style_t drive_style,
  output adc_cfg_pkg::coding_t coding,
  output logic ddr_enable,
  output logic loop_range_slow,
  // Data path
  input wire logic [WORD_WIDTH-1:0] sample_word,
  output logic [WORD_WIDTH-1:0] out_word,
  output logic test_active
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] port_config_q;
  logic [1:0] core_select_q;
  logic [7:0] power_down_q [CORES];
  logic [7:0] skew_q;
  logic [7:0] advance_q;
  logic [7:0] divider_q;
  logic [7:0] style_primary_q;
  logic [7:0] style_secondary_q;
  logic [7:0] loop_state_q;
  logic [7:0] test_control_q;
  logic [7:0] word_one_low_q;
  logic [7:0] word_one_high_q;
  logic [7:0] word_two_low_q;
  logic [7:0] word_two_high_q;
  logic divided_q;
  logic soft_reset;
  logic advance_cmd;
  logic [7:0] read_d;
  test_cfg_t test_cfg;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic write_to(input reg_req_t req, input logic [12:0] addr);
    write_to = req.wr && (req.addr == addr);
  endfunction : write_to

  function automatic power_state_t power_decode(input logic [7:0] field, input logic [1:0] pin);
    case (field[2:0])
      CODE_ONE: power_decode = POWER_NORMAL;
      CODE_TWO: power_decode = POWER_NAP;
      CODE_FOUR: power_decode = POWER_SLEEP;
      default: power_decode = power_state_t'(pin);
    endcase
  endfunction : power_decode

  function automatic logic core_hit(input logic [1:0] sel, input int core);
    core_hit = (core == 0) ? (sel == CORE_ZERO) : (sel == CORE_ONE);
  endfunction : core_hit

  // Soft reset is a one-cycle effect of the write; the bit itself does not stick
  assign soft_reset = write_to(reg_req, ADDR_PORT_CONFIG) && reg_req.wdata[SOFT_RESET_BIT];

  // ----------------------------------------------------------------
  // Port configuration and core select
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port_config_q <= RESET_ZERO;
    end else if (soft_reset) begin
      port_config_q <= RESET_ZERO;
    end else if (write_to(reg_req, ADDR_PORT_CONFIG)) begin
      port_config_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      core_select_q <= 2'h0;
    end else if (soft_reset) begin
      core_select_q <= 2'h0;
    end else if (write_to(reg_req, ADDR_CORE_SELECT)) begin
      core_select_q <= reg_req.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Exempt overrides: power-down, divider, primary output style
  // ----------------------------------------------------------------
  // No soft reset term here on purpose
  for (genvar c = 0; c < CORES; c++) begin : g_core
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        power_down_q[c] <= RESET_ZERO;
      end else if (write_to(reg_req, ADDR_POWER_DOWN) && core_hit(core_select_q, c)) begin
        power_down_q[c] <= reg_req.wdata;
      end
    end
    assign core_power[c] = power_decode(power_down_q[c], power_state_select_pin);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divider_q <= RESET_ZERO;
      style_primary_q <= RESET_ZERO;
    end else begin
      if (write_to(reg_req, ADDR_DIVIDER)) begin
        divider_q <= reg_req.wdata;
      end
      if (write_to(reg_req, ADDR_STYLE_PRIMARY)) begin
        style_primary_q <= reg_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Skew trim
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skew_q <= RESET_SKEW;
    end else if (soft_reset) begin
      skew_q <= RESET_SKEW;
    end else if (write_to(reg_req, ADDR_SKEW_TRIM)) begin
      skew_q <= reg_req.wdata;
    end
  end

  assign core_skew_trim = skew_q;

  // ----------------------------------------------------------------
  // Divider selection and divided clock
  // ----------------------------------------------------------------
  always_comb begin
    case (divider_q[2:0])
      CODE_ONE: divide_by_two = 1'b0;
      CODE_TWO: divide_by_two = 1'b1;
      // The forbidden code falls back to the pin rather than guessing
      default: divide_by_two = divisor_select_pin;
    endcase
  end

  // Advance fires on a one written after a stored zero, never on a repeated one
  assign advance_cmd = write_to(reg_req, ADDR_CLOCK_ADVANCE) && reg_req.wdata[0] && !advance_q[0];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      advance_q <= RESET_ZERO;
    end else if (soft_reset) begin
      advance_q <= RESET_ZERO;
    end else if (write_to(reg_req, ADDR_CLOCK_ADVANCE)) begin
      advance_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divided_q <= 1'b0;
    end else if (!divide_by_two) begin
      divided_q <= 1'b0;
    end else if (advance_cmd) begin
      divided_q <= 1'b1;
    end else begin
      divided_q <= ~divided_q;
    end
  end

  // Divide by one passes the input clock phase; only a marker is given here
  assign divided_clock = divided_q;

  // ----------------------------------------------------------------
  // Output style and coding
  // ----------------------------------------------------------------
  always_comb begin
    case (style_primary_q[7:5])
      CODE_ONE: drive_style = DRIVE_DIFF_2MA;
      CODE_TWO: drive_style = DRIVE_DIFF_3MA;
      CODE_FOUR: drive_style = DRIVE_CMOS;
      default: drive_style = drive_style_t'(output_style_select_pin);
    endcase
  end

  always_comb begin
    case (style_primary_q[2:0])
      CODE_ONE: coding = CODING_TWOS;
      CODE_TWO: coding = CODING_GRAY;
      CODE_FOUR: coding = CODING_OFFSET;
      default: coding = coding_t'(coding_select_pin);
    endcase
  end

  // ----------------------------------------------------------------
  // DDR and loop range
  // ----------------------------------------------------------------
  // Loop state holds the effective setting; a write of (old ^ state ^ want) lands on want
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      style_secondary_q <= RESET_ZERO;
      loop_state_q <= RESET_ZERO;
    end else if (soft_reset) begin
      style_secondary_q <= RESET_ZERO;
      loop_state_q <= RESET_ZERO;
    end else if (write_to(reg_req, ADDR_STYLE_SECONDARY)) begin
      style_secondary_q <= reg_req.wdata;
      loop_state_q <= reg_req.wdata ^ style_secondary_q ^ loop_state_q;
    end
  end

  assign loop_range_slow = loop_state_q[LOOP_RANGE_BIT];
  assign ddr_enable = loop_state_q[DDR_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Test pattern registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      test_control_q <= RESET_ZERO;
      word_one_low_q <= RESET_ZERO;
      word_one_high_q <= RESET_ZERO;
      word_two_low_q <= RESET_ZERO;
      word_two_high_q <= RESET_ZERO;
    end else if (soft_reset) begin
      test_control_q <= RESET_ZERO;
      word_one_low_q <= RESET_ZERO;
      word_one_high_q <= RESET_ZERO;
      word_two_low_q <= RESET_ZERO;
      word_two_high_q <= RESET_ZERO;
    end else begin
      if (write_to(reg_req, ADDR_TEST_CONTROL)) begin
        test_control_q <= reg_req.wdata;
      end
      if (write_to(reg_req, ADDR_WORD_ONE_LOW)) begin
        word_one_low_q <= reg_req.wdata;
      end
      if (write_to(reg_req, ADDR_WORD_ONE_HIGH)) begin
        word_one_high_q <= reg_req.wdata;
      end
      if (write_to(reg_req, ADDR_WORD_TWO_LOW)) begin
        word_two_low_q <= reg_req.wdata;
      end
      if (write_to(reg_req, ADDR_WORD_TWO_HIGH)) begin
        word_two_high_q <= reg_req.wdata;
      end
    end
  end

  assign test_cfg.pattern = test_control_q[3:0];
  assign test_cfg.mode = test_control_q[7:6];
  assign test_cfg.word_one = {word_one_high_q, word_one_low_q};
  assign test_cfg.word_two = {word_two_high_q, word_two_low_q};

  test_word_gen #(
    .WIDTH(WORD_WIDTH)
  ) u_test_word_gen (
    .clock(clock),
    .resetn(resetn),
    .cfg(test_cfg),
    .sample_word(sample_word),
    .out_word(out_word),
    .test_active(test_active)
  );

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_req.addr)
      ADDR_PORT_CONFIG: read_d = port_config_q;
      ADDR_CORE_SELECT: read_d = {6'h00, core_select_q};
      ADDR_POWER_DOWN: begin
        // Indexed read with no valid core returns the error code
        if (core_select_q == CORE_ZERO) begin
          read_d = power_down_q[0];
        end else if (core_select_q == CORE_ONE) begin
          read_d = power_down_q[1];
        end else begin
          read_d = NO_CORE_CODE;
        end
      end
      ADDR_SKEW_TRIM: read_d = skew_q;
      ADDR_CLOCK_ADVANCE: read_d = advance_q;
      ADDR_DIVIDER: read_d = divider_q;
      ADDR_STYLE_PRIMARY: read_d = style_primary_q;
      ADDR_STYLE_SECONDARY: read_d = style_secondary_q;
      ADDR_LOOP_STATE: read_d = loop_state_q;
      ADDR_TEST_CONTROL: read_d = test_control_q;
      ADDR_WORD_ONE_LOW: read_d = word_one_low_q;
      ADDR_WORD_ONE_HIGH: read_d = word_one_high_q;
      ADDR_WORD_TWO_LOW: read_d = word_two_low_q;
      ADDR_WORD_TWO_HIGH: read_d = word_two_high_q;
      default: read_d = RESET_ZERO;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RESET_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= read_d;
      end
    end
  end

endmodule : adc_config_test_register_bank

// ==== hdl/test_word_gen.sv ====
// Output test word generator between the register bank and the output bus.
// Assumes the configuration may change at any time.
`timescale 1ns/1ps
module test_word_gen
  import adc_cfg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration
  input adc_cfg_pkg::test_cfg_t cfg,
  // Data path
  input wire logic [WIDTH-1:0] sample_word,
  output logic [WIDTH-1:0] out_word,
  output logic test_active
);

  logic [TEST_SYNC_STAGES-1:0] enable_sync_q;
  logic phase_q;
  logic [WIDTH-1:0] word_one;
  logic [WIDTH-1:0] word_two;
  logic pattern_valid;
  logic alternate;

  // ----------------------------------------------------------------
  // Pattern words
  // ----------------------------------------------------------------
  always_comb begin
    pattern_valid = 1'b1;
    alternate = 1'b0;
    word_one = WORD_ZEROS;
    word_two = WORD_ZEROS;
    case (cfg.pattern)
      PAT_MID: word_one = WORD_MID;
      PAT_ONES: word_one = WORD_ONES;
      PAT_ZEROS: word_one = WORD_ZEROS;
      PAT_CHECKER: begin
        word_one = WORD_CHECK_A;
        word_two = WORD_CHECK_B;
        alternate = 1'b1;
      end
      PAT_ONE_ZERO: begin
        word_one = WORD_ONES;
        word_two = WORD_ZEROS;
        alternate = 1'b1;
      end
      PAT_USER: begin
        word_one = cfg.word_one;
        word_two = cfg.word_two;
        alternate = (cfg.mode == TEST_ALTERNATE);
      end
      default: pattern_valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Enable recognition
  // ----------------------------------------------------------------
  // Enable crosses into the sample path; test_active lags by the stage count, the pattern on out_word by one cycle more
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_sync_q <= '0;
    end else begin
      enable_sync_q <= {enable_sync_q[TEST_SYNC_STAGES-2:0], pattern_valid};
    end
  end

  assign test_active = enable_sync_q[TEST_SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // Output bus
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 1'b0;
    end else if (test_active) begin
      phase_q <= ~phase_q;
    end else begin
      phase_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_word <= '0;
    end else if (!test_active) begin
      out_word <= sample_word;
    end else if (alternate && phase_q) begin
      out_word <= word_two;
    end else begin
      out_word <= word_one;
    end
  end

endmodule : test_word_gen

// ==== sim/adc_cfg_asserts.sv ====
// Port checker for the register bank.
// Assumes a bind to the bank.
`timescale 1ns/1ps
module adc_cfg_asserts
  import adc_cfg_pkg::*;
#(
  parameter int WORD_WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Observed ports
  input adc_cfg_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] core_skew_trim,
  input wire logic divide_by_two,
  input wire logic divided_clock,
  input adc_cfg_pkg::drive_style_t drive_style,
  input adc_cfg_pkg::coding_t coding,
  input wire logic [WORD_WIDTH-1:0] sample_word,
  input wire logic [WORD_WIDTH-1:0] out_word,
  input wire logic test_active
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_adv(b);
    reg_req.wr && reg_req.addr == ADDR_CLOCK_ADVANCE && reg_req.wdata[0] == b;
  endsequence
  property p_rvalid; 1 |=> reg_rvalid == $past(reg_req.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid late");
  property p_skew; reg_req.wr && reg_req.addr == ADDR_SKEW_TRIM |=> core_skew_trim == $past(reg_req.wdata); endproperty
  a_skew: assert property (p_skew) else $error("skew stale");
  property p_div1; !divide_by_two [*2] |-> !divided_clock; endproperty
  a_div1: assert property (p_div1) else $error("clock moved");
  property p_advance; s_adv(0) ##1 (s_adv(1) and divide_by_two) |=> divided_clock; endproperty
  a_advance: assert property (p_advance) else $error("no advance");
  property p_pattern; reg_req.wr && reg_req.addr == ADDR_TEST_CONTROL && reg_req.wdata == 8'h02
    |=> ##[2:4] (test_active && out_word == WORD_ONES); endproperty
  a_pattern: assert property (p_pattern) else $error("pattern late");
  property p_off; $past(resetn) && !test_active && $past(!test_active) |-> out_word == $past(sample_word); endproperty
  a_off: assert property (p_off) else $error("no pass");
  property p_style; reg_req.wr && reg_req.addr == ADDR_STYLE_PRIMARY && reg_req.wdata == 8'h82
    |=> drive_style == DRIVE_CMOS && coding == CODING_GRAY; endproperty
  a_style: assert property (p_style) else $error("bad style");
  property p_unmapped; reg_req.rd && reg_req.addr == 13'h0001 |=> reg_rvalid && reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad read");
endmodule : adc_cfg_asserts

bind adc_config_test_register_bank adc_cfg_asserts #(.WORD_WIDTH(WORD_WIDTH)) i_chk (.clock, .resetn, .reg_req,
  .reg_rdata, .reg_rvalid, .core_skew_trim, .divide_by_two, .divided_clock, .drive_style, .coding, .sample_word,
  .out_word, .test_active);

// ==== sim/cfg_host_model.sv ====
// Host model for the byte register port.
// Assumes requests change on falling edges.
`timescale 1ns/1ps
module cfg_host_model
  import adc_cfg_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output adc_cfg_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    reg_req = '0;
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic ok);
    @(negedge clock);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    reg_req = '0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
  // Zero first, so a stale one never counts
  task automatic advance();
    @(negedge clock);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: ADDR_CLOCK_ADVANCE, wdata: 8'h00};
    @(negedge clock);
    reg_req.wdata = 8'h01;
    @(negedge clock);
    reg_req = '0;
  endtask : advance
  task automatic set_secondary(input logic [7:0] want);
    logic [7:0] b, s;
    logic ok;
    rd(ADDR_STYLE_SECONDARY, b, ok);
    rd(ADDR_LOOP_STATE, s, ok);
    wr(ADDR_STYLE_SECONDARY, b ^ s ^ want);
  endtask : set_secondary
endmodule : cfg_host_model

// ==== sim/tb_adc_config_test_register_bank.sv ====
// Self-checking bench for the register bank.
// Assumes the host model and checker are compiled too.
`timescale 1ns/1ps
module tb_adc_config_test_register_bank;
  import adc_cfg_pkg::*;
  logic clock, resetn, divisor_select_pin, reg_rvalid, divide_by_two, divided_clock, ddr_enable;
  logic loop_range_slow, test_active, ok;
  logic [1:0] power_state_select_pin, output_style_select_pin, coding_select_pin;
  logic [7:0] reg_rdata, core_skew_trim, rd;
  logic [15:0] sample_word, out_word;
  reg_req_t reg_req;
  power_state_t core_power [2];
  drive_style_t drive_style;
  coding_t coding;
  int errors, check_count;
  adc_config_test_register_bank i_dut (.clock, .resetn, .reg_req, .reg_rdata, .reg_rvalid, .power_state_select_pin,
    .divisor_select_pin, .output_style_select_pin, .coding_select_pin, .core_power, .core_skew_trim, .divide_by_two,
    .divided_clock, .drive_style, .coding, .ddr_enable, .loop_range_slow, .sample_word, .out_word, .test_active);
  cfg_host_model i_host (.clock, .reg_req, .reg_rdata, .reg_rvalid);
  // --------------------
  // Shared checks
  // --------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask : chb
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    i_host.rd(a, rd, ok);
    chb("reg_rvalid", 1'h1, ok);
    chk("reg_rdata", {8'h00, e}, {8'h00, rd});
  endtask : rdc
  task automatic pat(input logic [7:0] c, input logic [15:0] w1, input logic [15:0] w2);
    logic [15:0] a;
    i_host.wr(ADDR_TEST_CONTROL, c);
    repeat (6) @(negedge clock);
    chb("test_active", 1'h1, test_active);
    a = out_word;
    @(negedge clock);
    if (a === w1) chk("out_word", w2, out_word);
    else begin
      chk("out_word", w2, a);
      chk("out_word", w1, out_word);
    end
  endtask : pat
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs();
    rdc(ADDR_SKEW_TRIM, RESET_SKEW);
    rdc(ADDR_CORE_SELECT, 8'h00);
    rdc(ADDR_POWER_DOWN, NO_CORE_CODE);
    rdc(13'h0001, 8'h00);
    i_host.wr(ADDR_SKEW_TRIM, 8'hFF);
    rdc(ADDR_SKEW_TRIM, 8'hFF);
    chb("loop_range_slow", 1'h0, loop_range_slow);
  endtask : t_regs
  task automatic t_power();
    chk("core1", POWER_NAP, core_power[1]);
    i_host.wr(ADDR_CORE_SELECT, 8'h01);
    i_host.wr(ADDR_POWER_DOWN, 8'h04);
    chk("core0", POWER_SLEEP, core_power[0]);
    chk("core1", POWER_NAP, core_power[1]);
    i_host.wr(ADDR_POWER_DOWN, 8'h01);
    chk("core0", POWER_NORMAL, core_power[0]);
    i_host.wr(ADDR_POWER_DOWN, 8'h02);
    chk("core0", POWER_NAP, core_power[0]);
  endtask : t_power
  task automatic t_clock();
    i_host.wr(ADDR_DIVIDER, 8'h01);
    chb("divide_by_two", 1'h0, divide_by_two);
    i_host.advance();
    chb("divided_clock", 1'h0, divided_clock);
    i_host.wr(ADDR_DIVIDER, 8'h02);
    i_host.advance();
    chb("divided_clock", 1'h1, divided_clock);
    chb("divide_by_two", 1'h1, divide_by_two);
  endtask : t_clock
  task automatic t_style();
    chk("drive_style", DRIVE_DIFF_3MA, drive_style);
    i_host.wr(ADDR_STYLE_PRIMARY, 8'h21);
    chk("drive_style", DRIVE_DIFF_2MA, drive_style);
    chk("coding", CODING_TWOS, coding);
    i_host.wr(ADDR_STYLE_PRIMARY, 8'h44);
    chk("drive_style", DRIVE_DIFF_3MA, drive_style);
    chk("coding", CODING_OFFSET, coding);
    i_host.wr(ADDR_STYLE_PRIMARY, 8'h82);
  endtask : t_style
  task automatic t_soft();
    i_host.wr(ADDR_SKEW_TRIM, 8'h11);
    i_host.wr(ADDR_PORT_CONFIG, 8'h20);
    rdc(ADDR_SKEW_TRIM, RESET_SKEW);
    rdc(ADDR_CORE_SELECT, 8'h00);
    chb("divide_by_two", 1'h1, divide_by_two);
    chk("coding", CODING_GRAY, coding);
  endtask : t_soft
  task automatic t_loop();
    i_host.set_secondary(8'h50);
    chb("loop_range_slow", 1'h1, loop_range_slow);
    chb("ddr_enable", 1'h1, ddr_enable);
  endtask : t_loop
  task automatic t_test();
    i_host.wr(ADDR_WORD_ONE_LOW, 8'h34);
    i_host.wr(ADDR_WORD_ONE_HIGH, 8'h12);
    i_host.wr(ADDR_WORD_TWO_LOW, 8'h78);
    i_host.wr(ADDR_WORD_TWO_HIGH, 8'h56);
    pat(8'h48, 16'h1234, 16'h5678);
    pat(8'h08, 16'h1234, 16'h1234);
    pat(8'h01, WORD_MID, WORD_MID);
    pat(8'h02, WORD_ONES, WORD_ONES);
    pat(8'h03, WORD_ZEROS, WORD_ZEROS);
    pat(8'h44, WORD_CHECK_A, WORD_CHECK_B);
    pat(8'h47, WORD_ONES, WORD_ZEROS);
    i_host.wr(ADDR_TEST_CONTROL, 8'h05);
    repeat (6) @(negedge clock);
    chb("test_active", 1'h0, test_active);
    chk("out_word", sample_word, out_word);
  endtask : t_test
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    errors++;
    stop_test();
  end
  initial begin
    {resetn, divisor_select_pin, errors, check_count} = '0;
    {power_state_select_pin, output_style_select_pin, coding_select_pin} = 6'b01_01_10;
    sample_word = 16'h0F0F;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    t_regs();
    t_power();
    t_clock();
    t_style();
    t_soft();
    t_loop();
    t_test();
    stop_test();
  end
endmodule : tb_adc_config_test_register_bank
